/* File: shared/poll_cfg_pkg.sv */
// shared constants and types for the poll period and channel enable block
package poll_cfg_pkg;
	localparam int CHANNELS = 24;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;

	// register offsets
	localparam logic [5:0] OFS_SETUP = 6'h1a;
	localparam logic [5:0] OFS_CHAN_EN = 6'h1b;

	// reset values
	localparam logic [23:0] SETUP_RESET = 24'h000000;
	localparam logic [23:0] CHAN_EN_RESET = 24'h000000;

	// setup field positions
	localparam int SOFT_RESET_BIT = 0;
	localparam int POLL_TIME_LSB = 1;
	localparam int POLL_TIME_W = 4;
	localparam int POLL_EN_BIT = 10;
	localparam int RUN_BIT = 11;

	// timing: one millisecond at 100 MHz (10 ns period)
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned NS_PER_MS = 1000000;
	localparam int unsigned CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

	// poll periods in ms per selector code
	localparam int unsigned POLL_MS_0 = 2;
	localparam int unsigned POLL_MS_1 = 4;
	localparam int unsigned POLL_MS_2 = 8;
	localparam int unsigned POLL_MS_3 = 16;
	localparam int unsigned POLL_MS_4 = 32;
	localparam int unsigned POLL_MS_5 = 48;
	localparam int unsigned POLL_MS_6 = 64;
	localparam int unsigned POLL_MS_7 = 128;
	localparam int unsigned POLL_MS_8 = 256;
	localparam int unsigned POLL_MS_9 = 512;
	localparam int unsigned POLL_MS_A = 1024;
	localparam int unsigned POLL_MS_B = 2048;
	localparam int unsigned POLL_MS_C = 4096;
	localparam int unsigned POLL_MS_OTHER = 8;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_SCAN = 2'b01,
		SEQ_WAIT = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [23:0] wdata;
	} reg_req_t;

	function automatic int unsigned poll_ms(input logic [3:0] code);
		case (code)
			4'h0: poll_ms = POLL_MS_0;
			4'h1: poll_ms = POLL_MS_1;
			4'h2: poll_ms = POLL_MS_2;
			4'h3: poll_ms = POLL_MS_3;
			4'h4: poll_ms = POLL_MS_4;
			4'h5: poll_ms = POLL_MS_5;
			4'h6: poll_ms = POLL_MS_6;
			4'h7: poll_ms = POLL_MS_7;
			4'h8: poll_ms = POLL_MS_8;
			4'h9: poll_ms = POLL_MS_9;
			4'ha: poll_ms = POLL_MS_A;
			4'hb: poll_ms = POLL_MS_B;
			4'hc: poll_ms = POLL_MS_C;
			default: poll_ms = POLL_MS_OTHER;
		endcase
	endfunction : poll_ms
endpackage : poll_cfg_pkg

/* File: hdl/poll_period_and_channel_enable.sv */
// poll period selection, software reset and channel enable mask with polling sequencer
// Functional notes
// R1 - selector codes 0..C give 2..4096 ms periods; codes D..F give 8 ms
// R2 - writing one to setup bit 0 resets the configuration; zero does nothing
// R3 - channels with enable bit zero are skipped and never sampled
// R4 - channels with enable bit one are visited and sampled by the sequence
// R5 - enable mask is 24 bits, bit n controls channel n
// R6 - enable mask sits at offset 1b and resets to zero
// R7 - poll period used only when polling bit set, otherwise continuous scanning
// R8 - host clears run bit before reconfiguring, then sets it again
// R9 - software reset restores all registers; reset bit always reads zero
module poll_period_and_channel_enable #(
	parameter int unsigned CLKS_PER_MS = poll_cfg_pkg::CYCLES_PER_MS
) (
	input wire logic mclk, // 100 MHz clock
	input wire logic reset_n, // async power-on reset
	input wire poll_cfg_pkg::reg_req_t req, // decoded register access
	output logic [23:0] rdata, // read data, valid cycle after rd
	output logic [23:0] chan_active, // enable mask to the front end
	output logic sample_strobe, // one-cycle sample pulse
	output logic [4:0] sample_channel, // channel sampled with the pulse
	output logic polling_active // sequencer not idle
);
	// ==========================================================
	// register decode
	logic [23:0] setup;
	logic [23:0] chan_en;
	poll_cfg_pkg::seq_state_t state;
	logic [4:0] idx;
	logic [31:0] wait_cnt;

	wire hit_setup = req.addr == poll_cfg_pkg::OFS_SETUP;
	wire hit_chan = req.addr == poll_cfg_pkg::OFS_CHAN_EN; // see R6
	wire wr_setup = req.wr && hit_setup;
	wire wr_chan = req.wr && hit_chan;
	wire soft_reset = wr_setup && req.wdata[poll_cfg_pkg::SOFT_RESET_BIT]; // see R2
	wire run = setup[poll_cfg_pkg::RUN_BIT];
	wire poll_en = setup[poll_cfg_pkg::POLL_EN_BIT];
	wire [3:0] poll_code = setup[poll_cfg_pkg::POLL_TIME_LSB +: poll_cfg_pkg::POLL_TIME_W];
	wire [31:0] period_cycles = 32'(poll_cfg_pkg::poll_ms(poll_code) * CLKS_PER_MS); // see R1
	wire [23:0] next_setup = {req.wdata[23:1], 1'b0}; // see R9
	wire [23:0] read_mux = !req.rd ? rdata : hit_setup ? setup : hit_chan ? chan_en : 24'h000000;
	wire last_chan = idx == 5'(poll_cfg_pkg::CHANNELS - 1);
	wire take_sample = state == poll_cfg_pkg::SEQ_SCAN && chan_en[idx]; // see R3 R4
	wire [4:0] next_sample_channel = take_sample ? idx : sample_channel;

	// ==========================================================
	// registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			setup <= poll_cfg_pkg::SETUP_RESET;
			chan_en <= poll_cfg_pkg::CHAN_EN_RESET;
		end else if (soft_reset) begin
			setup <= poll_cfg_pkg::SETUP_RESET; // see R2 R9
			chan_en <= poll_cfg_pkg::CHAN_EN_RESET;
		end else begin
			if (wr_setup) begin
				setup <= next_setup;
			end
			if (wr_chan) begin
				chan_en <= req.wdata; // see R5
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 24'h000000;
			chan_active <= 24'h000000;
		end else begin
			rdata <= read_mux;
			chan_active <= chan_en;
		end
	end

	// ==========================================================
	// polling sequencer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= poll_cfg_pkg::SEQ_IDLE;
			idx <= 5'h00;
			wait_cnt <= 32'h00000000;
		end else if (!run) begin
			state <= poll_cfg_pkg::SEQ_IDLE;
			idx <= 5'h00;
			wait_cnt <= 32'h00000000;
		end else begin
			case (state)
				poll_cfg_pkg::SEQ_IDLE: begin
					state <= poll_cfg_pkg::SEQ_SCAN;
					idx <= 5'h00;
				end
				poll_cfg_pkg::SEQ_SCAN: begin
					if (last_chan) begin
						idx <= 5'h00;
						if (poll_en) begin
							state <= poll_cfg_pkg::SEQ_WAIT; // see R7
							wait_cnt <= period_cycles;
						end
					end else begin
						idx <= idx + 5'h01;
					end
				end
				poll_cfg_pkg::SEQ_WAIT: begin
					if (wait_cnt <= 32'h00000001) begin
						state <= poll_cfg_pkg::SEQ_SCAN;
						wait_cnt <= 32'h00000000;
					end else begin
						wait_cnt <= wait_cnt - 32'h00000001;
					end
				end
				default: begin
					state <= poll_cfg_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sample_strobe <= 1'b0;
			sample_channel <= 5'h00;
			polling_active <= 1'b0;
		end else begin
			sample_strobe <= take_sample; // see R3 R4
			sample_channel <= next_sample_channel;
			polling_active <= run;
		end
	end

	// ==========================================================
	// assertion helpers
	// cycles spent in the poll wait, and the period loaded for it
	logic [31:0] gap_len;
	logic [31:0] gap_goal;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			gap_len <= 32'h00000000;
			gap_goal <= 32'h00000000;
		end else if (state == poll_cfg_pkg::SEQ_WAIT) begin
			gap_len <= gap_len + 32'h00000001;
		end else begin
			gap_len <= 32'h00000000;
			gap_goal <= period_cycles;
		end
	end

	// ==========================================================
	// assertions
	chk_period_load: assert property (@(posedge mclk) disable iff (!reset_n) // see R1
		(run && state == poll_cfg_pkg::SEQ_SCAN && last_chan && poll_en && !soft_reset)
		|=> (state == poll_cfg_pkg::SEQ_WAIT && wait_cnt == 32'(poll_cfg_pkg::poll_ms($past(poll_code)) * CLKS_PER_MS)))
		else $error("poll period not loaded from selector");
	chk_soft_reset: assert property (@(posedge mclk) disable iff (!reset_n) // see R2
		soft_reset |=> (setup == poll_cfg_pkg::SETUP_RESET && chan_en == poll_cfg_pkg::CHAN_EN_RESET))
		else $error("software reset did not restore registers");
	chk_zero_noreset: assert property (@(posedge mclk) disable iff (!reset_n) // see R2
		(wr_setup && !req.wdata[0]) |=> setup == {$past(req.wdata[23:1]), 1'b0})
		else $error("setup write with bit 0 clear misbehaved");
	chk_skip_disabled: assert property (@(posedge mclk) disable iff (!reset_n) // see R3
		(state == poll_cfg_pkg::SEQ_SCAN && !chan_en[idx]) |=> !sample_strobe)
		else $error("disabled channel sampled");
	chk_visit_enabled: assert property (@(posedge mclk) disable iff (!reset_n) // see R4
		(state == poll_cfg_pkg::SEQ_SCAN && chan_en[idx]) |=> (sample_strobe && sample_channel == $past(idx)))
		else $error("enabled channel not sampled");
	chk_mask_write: assert property (@(posedge mclk) disable iff (!reset_n) // see R5
		(wr_chan && !soft_reset) |=> ##1 chan_active == $past(req.wdata, 2))
		else $error("enable mask not stored bit for bit");
	chk_mask_read: assert property (@(posedge mclk) disable iff (!reset_n) // see R6
		(req.rd && req.addr == 6'h1b) |=> rdata == $past(chan_en))
		else $error("enable mask read at wrong offset");
	chk_continuous: assert property (@(posedge mclk) disable iff (!reset_n) // see R7
		(run && state == poll_cfg_pkg::SEQ_SCAN && last_chan && !poll_en && !soft_reset)
		|=> (state == poll_cfg_pkg::SEQ_SCAN && idx == 5'h00))
		else $error("continuous mode did not rescan at once");
	chk_reset_bit_zero: assert property (@(posedge mclk) disable iff (!reset_n) // see R9
		(req.rd && hit_setup) |=> !rdata[0])
		else $error("reset request bit read back as one");
	chk_code_other: assert property (@(posedge mclk) disable iff (!reset_n) // see R1
		(poll_code > 4'hc) |-> period_cycles == 32'(poll_cfg_pkg::POLL_MS_OTHER * CLKS_PER_MS))
		else $error("upper selector code not given the default period");
	chk_wait_count: assert property (@(posedge mclk) disable iff (!reset_n) // see R1
		(run && state == poll_cfg_pkg::SEQ_WAIT && wait_cnt > 32'h00000001)
		|=> (state == poll_cfg_pkg::SEQ_WAIT && wait_cnt == $past(wait_cnt) - 32'h00000001))
		else $error("poll wait counter did not step down");
	chk_wait_exit: assert property (@(posedge mclk) disable iff (!reset_n) // see R7
		(run && state == poll_cfg_pkg::SEQ_WAIT && wait_cnt <= 32'h00000001)
		|=> (state == poll_cfg_pkg::SEQ_SCAN && idx == 5'h00))
		else $error("scan did not restart after the poll wait");
	chk_wait_span: assert property (@(posedge mclk) disable iff (!reset_n) // see R1
		(run && state == poll_cfg_pkg::SEQ_WAIT && wait_cnt <= 32'h00000001)
		|-> gap_len == gap_goal - 32'h00000001)
		else $error("poll wait length differs from the selected period");
	chk_idle_start: assert property (@(posedge mclk) disable iff (!reset_n) // see R4
		(run && state == poll_cfg_pkg::SEQ_IDLE) |=> (state == poll_cfg_pkg::SEQ_SCAN && idx == 5'h00))
		else $error("sequence did not start at channel 0");
	chk_scan_step: assert property (@(posedge mclk) disable iff (!reset_n) // see R4
		(run && state == poll_cfg_pkg::SEQ_SCAN && !last_chan)
		|=> (state == poll_cfg_pkg::SEQ_SCAN && idx == $past(idx) + 5'h01))
		else $error("scan skipped or repeated a channel slot");
	chk_idx_range: assert property (@(posedge mclk) disable iff (!reset_n) // see R5
		idx <= 5'h17)
		else $error("channel index left the channel range");
	chk_idle_quiet: assert property (@(posedge mclk) disable iff (!reset_n) // see R3
		(state != poll_cfg_pkg::SEQ_SCAN) |=> !sample_strobe)
		else $error("channel sampled outside a scan");
	chk_strobe_mask: assert property (@(posedge mclk) disable iff (!reset_n) // see R3
		sample_strobe |-> chan_active[sample_channel])
		else $error("sample taken on a masked channel");
	chk_mask_hold: assert property (@(posedge mclk) disable iff (!reset_n) // see R5
		(!wr_chan && !soft_reset) |=> chan_en == $past(chan_en))
		else $error("enable mask changed without a write");
	chk_setup_hold: assert property (@(posedge mclk) disable iff (!reset_n) // see R2
		!wr_setup |=> setup == $past(setup))
		else $error("setup changed without a write");
	chk_unmapped_read: assert property (@(posedge mclk) disable iff (!reset_n) // see R6
		(req.rd && !hit_setup && !hit_chan) |=> rdata == 24'h000000)
		else $error("unmapped read returned data");
	chk_rdata_hold: assert property (@(posedge mclk) disable iff (!reset_n) // see R6
		!req.rd |=> rdata == $past(rdata))
		else $error("read data changed without a read");
	chk_soft_stop: assert property (@(posedge mclk) disable iff (!reset_n) // see R9
		soft_reset |=> ##1 (state == poll_cfg_pkg::SEQ_IDLE && !polling_active))
		else $error("software reset left the sequencer running");
endmodule : poll_period_and_channel_enable

/* File: verification/poll_host.sv */
// host model issuing register requests to the configuration block
module poll_host (
	input wire logic mclk, // 100 MHz clock
	output poll_cfg_pkg::reg_req_t req // register request to the block
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	// one access per call; released data lines flip so stale data is never seen
	task automatic access(input logic w, input logic [5:0] a, input logic [23:0] d);
		@(negedge mclk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : access
	// stop, reconfigure, restart
	task automatic setup(input logic [23:0] mask, input logic [23:0] cfg);
		access(1'b1, poll_cfg_pkg::OFS_SETUP, 24'h000000);
		access(1'b1, poll_cfg_pkg::OFS_CHAN_EN, mask);
		access(1'b1, poll_cfg_pkg::OFS_SETUP, cfg);
	endtask : setup
endmodule : poll_host

/* File: verification/poll_period_and_channel_enable_tb_top.sv */
// testbench for the poll period and channel enable block
module poll_period_and_channel_enable_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned CPM = 4;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	poll_cfg_pkg::reg_req_t req;
	logic [23:0] rdata;
	logic [23:0] chan_active;
	logic sample_strobe;
	logic polling_active;
	logic [4:0] sample_channel;
	logic [23:0] v;
	int bad_count = 0;
	int tests_run = 0;
	int ms[16] = '{2, 4, 8, 16, 32, 48, 64, 128, 256, 512, 1024, 2048, 4096, 8, 8, 8};
	initial forever #5 mclk = ~mclk;
	poll_host host (.mclk(mclk), .req(req));
	poll_period_and_channel_enable #(.CLKS_PER_MS(CPM)) dut (.mclk(mclk), .reset_n(reset_n), .req(req),
		.rdata(rdata), .chan_active(chan_active), .sample_strobe(sample_strobe),
		.sample_channel(sample_channel), .polling_active(polling_active));
	// ====================================
	// shared tasks
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic rd(input logic [5:0] a, output logic [23:0] r);
		host.access(1'b0, a, 24'h000000);
		@(negedge mclk);
		r = rdata;
	endtask : rd
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// ====================================
	// scenarios
	task automatic t_reset();
		rd(6'h1a, v);
		check(v, 24'h000000);
		rd(6'h1b, v);
		check(v, 24'h000000);
		rd(6'h00, v);
		check(v, 24'h000000);
		check(chan_active, 24'h000000);
	endtask : t_reset
	task automatic t_mask();
		host.access(1'b1, 6'h1b, 24'h800001);
		host.access(1'b1, 6'h3f, 24'h123456);
		rd(6'h1b, v);
		check(v, 24'h800001);
		check(chan_active, 24'h800001);
	endtask : t_mask
	task automatic t_scan();
		logic [23:0] seen;
		int n;
		seen = 24'h000000;
		n = 0;
		host.setup(24'h810005, 24'h000800);
		repeat (30) @(negedge mclk);
		for (int i = 0; i < 48; i++) begin
			@(negedge mclk);
			if (sample_strobe === 1'b1) begin
				seen[sample_channel] = 1'b1;
				n++;
			end
		end
		check(seen, 24'h810005);
		check(24'(n), 24'h000008);
		check({23'h0, polling_active}, 24'h000001);
	endtask : t_scan
	task automatic gap(input logic [23:0] cfg, input int lo);
		int n;
		host.setup(24'h000001, cfg);
		n = 0;
		while (sample_strobe !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (sample_strobe !== 1'b1 && n < 20000);
		check(24'(n), 24'(lo));
		check({19'h0, sample_channel}, 24'h000000);
	endtask : gap
	task automatic t_soft();
		host.setup(24'h00f00f, 24'h000c02);
		rd(6'h1a, v);
		check(v, 24'h000c02);
		rd(6'h1b, v);
		check(v, 24'h00f00f);
		host.access(1'b1, 6'h1a, 24'h000c03);
		rd(6'h1a, v);
		check(v, 24'h000000);
		rd(6'h1b, v);
		check(v, 24'h000000);
		check(chan_active, 24'h000000);
		check({23'h0, polling_active}, 24'h000000);
	endtask : t_soft
	task automatic t_hw_reset();
		host.setup(24'h00ff00, 24'h000800);
		repeat (5) @(negedge mclk);
		check(chan_active, 24'h00ff00);
		reset_n = 1'b0;
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		check({23'h0, polling_active}, 24'h000000);
		rd(6'h1b, v);
		check(v, 24'h000000);
		check(chan_active, 24'h000000);
		rd(6'h1a, v);
		check(v, 24'h000000);
	endtask : t_hw_reset
	// ====================================
	// main sequence and watchdog
	initial begin
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		t_reset();
		t_mask();
		t_scan();
		gap(24'h000800, 24);
		for (int i = 0; i < 16; i++) begin
			gap(24'h000c00 | {19'h0, 4'(i), 1'b0}, 24 + ms[i] * CPM);
		end
		t_hw_reset();
		t_soft();
		summarize();
	end
	initial begin
		#600000;
		bad_count++;
		summarize();
	end
endmodule : poll_period_and_channel_enable_tb_top
